// >>> logic/cam_latch_pkg.sv
// Constants and carriers for the cam switch, latch and output stage
`default_nettype none
package cam_latch_pkg;
    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int STEP_MAX = 16;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_LOWER = 8'h04;
    localparam logic [7:0] OFS_UPPER = 8'h08;
    localparam logic [7:0] OFS_LINK = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_STEP0 = 8'h40;
    localparam logic [7:0] OFS_STEP_END = 8'h80;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_LEVEL_BIT = 0;
    localparam int CTRL_WIDE_BIT = 1;
    localparam int CTRL_STEPS_LSB = 8;
    localparam int LINK_LATCH1_LSB = 8;
    localparam int LINK_OUT_LSB = 16;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] RST_CTRL = 32'h0000_0000;
    localparam logic [31:0] RST_LOWER = 32'h8000_0000;
    localparam logic [31:0] RST_UPPER = 32'h7FFF_FFFF;
    localparam logic [31:0] RST_STEP = 32'h0000_0000;
    localparam logic [31:0] RST_LINK = 32'h0000_0000;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    // Sources linked to one latch: events and its own comparator
    typedef struct packed {
        logic rst_cmp;
        logic [1:0] rst_evt;
        logic set_cmp;
        logic [1:0] set_evt;
    } latch_link_t;

    // Sources linked to the output terminal
    typedef struct packed {
        logic [1:0] latch;
        logic [1:0] evt;
    } out_link_t;
endpackage
`default_nettype wire

// >>> logic/cam_switch_latch_output.sv
// Cam switch, set/reset latches and output terminal with APB registers
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module cam_switch_latch_output (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [31:0] count_value,
    input wire logic [1:0] evt_in,
    input wire logic [1:0] cmp_in,
    output logic cam_out,
    output logic [1:0] latch_out,
    output logic result_out
);
    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    logic [31:0] ctrl_ff;
    logic [31:0] lower_ff;
    logic [31:0] upper_ff;
    logic [31:0] link_ff;
    logic [31:0] step_ff [cam_latch_pkg::STEP_MAX];
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic cam_ff;
    logic [1:0] latch_ff;
    logic result_ff;

    logic level;
    logic wide;
    logic [4:0] steps;
    cam_latch_pkg::latch_link_t link0;
    cam_latch_pkg::latch_link_t link1;
    cam_latch_pkg::out_link_t olink;
    logic nxt_cam;
    logic [1:0] nxt_latch;
    logic nxt_result;
    logic acc;
    logic wr_en;
    logic step_hit;
    logic [3:0] step_idx;
    logic mapped;
    logic [31:0] rd_val;

    assign level = ctrl_ff[cam_latch_pkg::CTRL_LEVEL_BIT];
    assign wide = ctrl_ff[cam_latch_pkg::CTRL_WIDE_BIT];
    assign steps = ctrl_ff[cam_latch_pkg::CTRL_STEPS_LSB +: 5];
    assign link0 = link_ff[5:0];
    assign link1 = link_ff[cam_latch_pkg::LINK_LATCH1_LSB +: 6];
    assign olink = link_ff[cam_latch_pkg::LINK_OUT_LSB +: 4];

    // Next latch state: reset beats set, else hold
    // set holds High
    function automatic logic latch_next(input logic cur,
                                        input cam_latch_pkg::latch_link_t l,
                                        input logic [1:0] evt,
                                        input logic cmp);
        logic s;
        logic r;
        s = (|(l.set_evt & evt)) | (l.set_cmp & cmp);
        r = (|(l.rst_evt & evt)) | (l.rst_cmp & cmp);
        if (r) begin
            latch_next = 1'b0;
        end else if (s) begin
            latch_next = 1'b1;
        end else begin
            latch_next = cur;
        end
    endfunction

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    // One wait state: pready rises in the second access cycle
    assign acc = psel & penable & ~pready_ff;
    assign wr_en = acc & pwrite & mapped;
    assign step_hit = (paddr >= cam_latch_pkg::OFS_STEP0) &&
                      (paddr < cam_latch_pkg::OFS_STEP_END);
    assign step_idx = paddr[5:2];

    // Read mux and address map
    always_comb begin
        rd_val = cam_latch_pkg::RD_ZERO;
        mapped = (paddr[1:0] == 2'h0);
        if (step_hit) begin
            rd_val = step_ff[step_idx];
        end else begin
            case (paddr)
                cam_latch_pkg::OFS_CTRL: rd_val = ctrl_ff;
                cam_latch_pkg::OFS_LOWER: rd_val = lower_ff;
                cam_latch_pkg::OFS_UPPER: rd_val = upper_ff;
                cam_latch_pkg::OFS_LINK: rd_val = link_ff;
                cam_latch_pkg::OFS_STATUS:
                    rd_val = {28'h000_0000, result_ff, latch_ff, cam_ff};
                default: mapped = 1'b0;
            endcase
        end
    end

    // Bus answer registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= cam_latch_pkg::RD_ZERO;
        end else begin
            pready_ff <= acc;
            pslverr_ff <= acc & ~mapped;
            prdata_ff <= (acc & ~pwrite & mapped) ? rd_val :
                         cam_latch_pkg::RD_ZERO;
        end
    end

    // Writable registers; status is read only
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_ff <= cam_latch_pkg::RST_CTRL;
            lower_ff <= cam_latch_pkg::RST_LOWER;
            upper_ff <= cam_latch_pkg::RST_UPPER;
            link_ff <= cam_latch_pkg::RST_LINK;
            for (int i = 0; i < cam_latch_pkg::STEP_MAX; i++) begin
                step_ff[i] <= cam_latch_pkg::RST_STEP;
            end
        end else if (wr_en) begin
            if (step_hit) begin
                step_ff[step_idx] <= pwdata;
            end else begin
                case (paddr)
                    cam_latch_pkg::OFS_CTRL: ctrl_ff <= pwdata & 32'h0000_1F03;
                    cam_latch_pkg::OFS_LOWER: lower_ff <= pwdata;
                    cam_latch_pkg::OFS_UPPER: upper_ff <= pwdata;
                    cam_latch_pkg::OFS_LINK: link_ff <= pwdata & 32'h000F_3F3F;
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Cam switch
    // ------------------------------------------------------------
    // parity toggle: each active step reached inverts state
    // active steps: only the first 'steps' thresholds, max 16
    // level select: High level inverts the pattern
    always_comb begin
        nxt_cam = level;
        for (int i = 0; i < cam_latch_pkg::STEP_MAX; i++) begin
            if ((5'(i) < steps) &&
                ($signed(count_value) >= $signed(step_ff[i]))) begin
                nxt_cam = ~nxt_cam;
            end
        end
        // Outside the limits the cam rests at the lower level
        if (($signed(count_value) < $signed(lower_ff)) ||
            ($signed(count_value) > $signed(upper_ff))) begin
            nxt_cam = level;
        end
    end

    // cam register: single bit on dedicated pin
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cam_ff <= 1'b0;
        end else begin
            cam_ff <= nxt_cam;
        end
    end

    // ------------------------------------------------------------
    // Set/reset latches and output terminal
    // ------------------------------------------------------------
    // comparator pairing: latch n sees comparator n only
    // latch count: second latch held Low in 32-bit mode
    always_comb begin
        nxt_latch[0] = latch_next(latch_ff[0], link0, evt_in, cmp_in[0]);
        nxt_latch[1] = wide ? 1'b0 :
                       latch_next(latch_ff[1], link1, evt_in, cmp_in[1]);
        // OR combine: all linked sources; none linked gives Low
        nxt_result = (|(olink.evt & evt_in)) | (|(olink.latch & nxt_latch));
    end

    // registered outputs: latches and result updated each edge
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            latch_ff <= 2'b00;
            result_ff <= 1'b0;
        end else begin
            latch_ff <= nxt_latch;
            result_ff <= nxt_result;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign cam_out = cam_ff;
    assign latch_out = latch_ff;
    assign result_out = result_ff;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    below_first_a: assert property (
        ($signed(count_value) >= $signed(lower_ff)) &&
        ($signed(count_value) < $signed(step_ff[0])) &&
        ($signed(count_value) <= $signed(upper_ff)) && $stable(step_ff[0])
        |=> cam_out == $past(level))
        else $error("cam not at lower level below first step");

    first_step_a: assert property (
        !level && steps >= 5'd2 &&
        ($signed(count_value) >= $signed(step_ff[0])) &&
        ($signed(count_value) < $signed(step_ff[1])) &&
        ($signed(count_value) >= $signed(lower_ff)) &&
        ($signed(count_value) <= $signed(upper_ff)) &&
        ($signed(step_ff[0]) < $signed(step_ff[1]))
        |=> cam_out)
        else $error("cam not High after first step");

    second_step_a: assert property (
        !level && steps == 5'd2 &&
        ($signed(count_value) >= $signed(step_ff[1])) &&
        ($signed(step_ff[0]) < $signed(step_ff[1])) &&
        ($signed(count_value) >= $signed(lower_ff)) &&
        ($signed(count_value) <= $signed(upper_ff))
        |=> !cam_out)
        else $error("cam not Low after second step");

    zero_steps_a: assert property (
        steps == 5'd0 ##1 steps == 5'd0 |-> cam_out == $past(level))
        else $error("cam toggled with no active steps");

    level_invert_a: assert property (
        $changed(level) && $stable(count_value) && $stable(steps)
        |=> $changed(cam_out))
        else $error("level change did not invert cam");

    wide_latch_a: assert property (
        wide |=> !latch_out[1])
        else $error("second latch active in 32-bit mode");

    set_hold_a: assert property (
        latch_out[0] && !(|(link0.rst_evt & evt_in)) &&
        !(link0.rst_cmp & cmp_in[0]) |=> latch_out[0])
        else $error("latch dropped without reset");

    reset_wins_a: assert property (
        ((|(link0.rst_evt & evt_in)) || (link0.rst_cmp & cmp_in[0])) &&
        ((|(link0.set_evt & evt_in)) || (link0.set_cmp & cmp_in[0]))
        |=> !latch_out[0])
        else $error("set beat reset on latch");

    cmp_pair_a: assert property (
        !latch_out[0] && !(|(link0.set_evt & evt_in)) &&
        !(link0.set_cmp & cmp_in[0]) && cmp_in[1] |=> !latch_out[0])
        else $error("latch set by foreign comparator");

    unlinked_low_a: assert property (
        olink == 4'h0 |=> !result_out)
        else $error("unlinked terminal drove result");

    or_combine_a: assert property (
        olink.latch[0] && $stable(olink) ##1 latch_out[0] |-> result_out)
        else $error("linked latch not on result");

endmodule // cam_switch_latch_output
`default_nettype wire

// >>> sim/count_pin_model.sv
// Counter timer and module pin model feeding count, events, comparators
`timescale 1ns/100ps
`default_nettype none
module count_pin_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [31:0] cmd_count,
    input wire logic [1:0] cmd_evt,
    input wire logic [1:0] cmd_cmp,
    output logic [31:0] count_value,
    output logic [1:0] evt_in,
    output logic [1:0] cmp_in
);
    // Registered drive, as the real counter updates on the clock
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            count_value <= 32'h0000_0000;
            evt_in <= 2'h0;
            cmp_in <= 2'h0;
        end else begin
            count_value <= cmd_count;
            evt_in <= cmd_evt;
            cmp_in <= cmd_cmp;
        end
    end
endmodule // count_pin_model
`default_nettype wire

// >>> sim/cam_switch_latch_output_tb_top.sv
// Self-checking bench for the cam switch, latch and output stage
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin \
    num_errors++; $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module cam_switch_latch_output_tb_top;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] cmd_count = 32'h0000_0000;
    logic [1:0] cmd_evt = 2'h0;
    logic [1:0] cmd_cmp = 2'h0;
    logic [31:0] count_value;
    logic [1:0] evt_in;
    logic [1:0] cmp_in;
    logic cam_out;
    logic [1:0] latch_out;
    logic result_out;
    logic [31:0] rd_v;
    logic err_v;
    int num_errors = 0;
    int checks_done = 0;
    logic [7:0] rs_ofs[5] = '{cam_latch_pkg::OFS_CTRL,
        cam_latch_pkg::OFS_LOWER, cam_latch_pkg::OFS_UPPER,
        cam_latch_pkg::OFS_LINK, cam_latch_pkg::OFS_STEP0};
    logic [31:0] rs_val[5] = '{32'h0000_0000, 32'h8000_0000,
        32'h7FFF_FFFF, 32'h0000_0000, 32'h0000_0000};
    logic [31:0] cfg[7] = '{32'h0000_0000, 32'h0000_0200, 32'h0000_0201,
        32'h0000_0600, 32'h0000_0601, 32'h0000_1000, 32'h0000_1001};
    int cnt[12] = '{-10, 99, 100, 249, 250, 400, 551, 700, 849, 850,
        2300, 2400};
    logic [1:0] pe[5] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2};
    logic [1:0] pc[5] = '{2'h2, 2'h1, 2'h0, 2'h1, 2'h0};
    logic [1:0] el[5] = '{2'h2, 2'h3, 2'h2, 2'h2, 2'h0};
    logic er[5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};

    always #5 ref_clk = ~ref_clk;

    cam_switch_latch_output dut (.ref_clk(ref_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .count_value(count_value), .evt_in(evt_in), .cmp_in(cmp_in),
        .cam_out(cam_out), .latch_out(latch_out), .result_out(result_out));

    count_pin_model far_side (.ref_clk(ref_clk), .rst(rst),
        .cmd_count(cmd_count), .cmd_evt(cmd_evt), .cmd_cmp(cmd_cmp),
        .count_value(count_value), .evt_in(evt_in), .cmp_in(cmp_in));

    // Expected cam level: invert once per reached active step
    function automatic logic exp_cam(input int c, input logic [31:0] g);
        int n;
        logic k;
        n = (g[12:8] > 5'd16) ? 16 : int'(g[12:8]);
        k = g[0];
        for (int i = 0; i < n; i++) begin
            if (c >= 100 + 150 * i) k = ~k;
        end
        return k;
    endfunction

    // One APB transfer, held until pready, data taken in that cycle
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // Access phase: pready, data and error taken at one rising edge
        @(posedge ref_clk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge ref_clk);
        end
        if (n == 20) num_errors++;
        rd_v = prdata;
        err_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] ex);
        apb(1'b0, a, 32'h0000_0000);
        `CHK("read data", ex, rd_v)
    endtask

    // Wait for model and design registers, sample mid-cycle
    task automatic settle();
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    task automatic pulse(input logic [1:0] e, input logic [1:0] c);
        @(posedge ref_clk);
        cmd_evt <= e;
        cmd_cmp <= c;
        @(posedge ref_clk);
        cmd_evt <= 2'h0;
        cmd_cmp <= 2'h0;
        settle();
    endtask

    task automatic print_verdict();
        if (num_errors == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        foreach (rs_ofs[i]) rchk(rs_ofs[i], rs_val[i]);
        apb(1'b0, 8'h20, 32'h0000_0000);
        `CHK("unmapped error", 1'b1, err_v)
        apb(1'b1, 8'h42, 32'h0000_0005);
        `CHK("misaligned error", 1'b1, err_v)
        for (int i = 0; i < 16; i++) begin
            apb(1'b1, 8'(cam_latch_pkg::OFS_STEP0 + 4 * i), 32'(100 + 150 * i));
        end
        rchk(8'h54, 32'h0000_0352);
        foreach (cfg[k]) begin
            apb(1'b1, cam_latch_pkg::OFS_CTRL, cfg[k]);
            foreach (cnt[j]) begin
                @(posedge ref_clk);
                cmd_count <= cnt[j];
                settle();
                `CHK("cam_out", exp_cam(cnt[j], cfg[k]), cam_out)
            end
        end
        apb(1'b1, cam_latch_pkg::OFS_CTRL, 32'h0000_0000);
        apb(1'b1, cam_latch_pkg::OFS_LINK, 32'h0004_140C);
        foreach (pe[i]) begin
            pulse(pe[i], pc[i]);
            `CHK("latch_out", el[i], latch_out)
            `CHK("result_out", er[i], result_out)
        end
        apb(1'b1, cam_latch_pkg::OFS_LINK, 32'h0000_140C);
        pulse(2'h0, 2'h1);
        `CHK("unlinked result", 1'b0, result_out)
        apb(1'b1, cam_latch_pkg::OFS_LINK, 32'h0006_140C);
        settle();
        `CHK("or result", 1'b1, result_out)
        apb(1'b1, cam_latch_pkg::OFS_LINK, 32'h0002_0400);
        @(posedge ref_clk);
        cmd_evt <= 2'h2;
        settle();
        `CHK("event result", 1'b1, result_out)
        @(posedge ref_clk);
        cmd_evt <= 2'h0;
        settle();
        `CHK("event result", 1'b0, result_out)
        apb(1'b1, cam_latch_pkg::OFS_CTRL, 32'h0000_0002);
        pulse(2'h0, 2'h2);
        `CHK("wide latch1", 1'b0, latch_out[1])
        apb(1'b1, cam_latch_pkg::OFS_CTRL, 32'h0000_0000);
        pulse(2'h0, 2'h2);
        `CHK("narrow latch1", 1'b1, latch_out[1])
        print_verdict();
    end

    // Watchdog well beyond the expected run of some 600 cycles
    initial begin
        #200us;
        num_errors++;
        print_verdict();
    end
endmodule // cam_switch_latch_output_tb_top
`default_nettype wire
